// ### src/instr_core_defs.vh
// Operation
// - rotate right plain: one cycle, acc or memory target, no flags change
// - rotate right through carry: one cycle, acc or memory, carry only
// - rotate left plain: one cycle, acc or memory target, no flags change
// - rotate left through carry: one cycle, acc or memory, carry only
// - moves memory/acc/immediate take one cycle and touch no flags
// - single bit set or clear of memory: one cycle, no flags
// - unconditional jump loads target, two cycles, no flags
// - skip family skips next instruction on its test, no flags change
// - skip instruction takes two cycles when skipping, one otherwise
// - call and all returns take two cycles, no flags except iret setting interrupt enable
// - current page table read: high byte to table register, low to memory
// - last page table read: same but from last program page, two cycles
// - no-operation takes one cycle and only advances program counter
// - whole byte clear or set of memory: one cycle, no flags
// - single watchdog clear: one cycle, restart watchdog, clear both flags
// - preclear pair clears watchdog and flags only when run back to back
// - nibble swap in place or to acc, one cycle, no flags
// - halt enters power down and updates timeout and power down flags
// - any write of program counter low byte makes the instruction two cycles
// - halt stops execution, keeps memory, clears watchdog, sets power down, clears timeout
// - call pushes next address then loads target, two cycles
`ifndef INSTR_CORE_DEFS_VH
`define INSTR_CORE_DEFS_VH

`define ADR_INSTR     14'h0000
`define ADR_STATUS    14'h0004
`define ADR_ACC       14'h0008
`define ADR_PC        14'h000C
`define ADR_TABHI     14'h0010
`define ADR_CTRL      14'h0014
`define ADR_CYCLES    14'h0018
`define ADR_DMEM_BASE 14'h0100
`define ADR_PMEM_BASE 14'h2000

`define OP_LSB  0
`define OP_MSB  5
`define BIT_LSB 6
`define BIT_MSB 8
`define MA_LSB  10
`define MA_MSB  15
`define IMM_LSB 16
`define IMM_MSB 23
`define TGT_LSB 16
`define TGT_MSB 26

`define PCLOW_LOC 6'h02
`define TBLP_LOC 6'h03
`define LAST_PAGE 3'h7

`define ST_BUSY  0
`define ST_PWRDN 1
`define ST_TO    2
`define ST_CARRY 3
`define ST_SLEEP 4
`define ST_SKIP  5
`define ST_IEN   6
`define CT_WAKE  0
`define CT_WDTEN 1

`define WDT_PERIOD 16'hFFFF

`define OP_NOP       6'h00
`define OP_ROR_ACC   6'h01
`define OP_ROR_MEM   6'h02
`define OP_RORC_ACC  6'h03
`define OP_RORC_MEM  6'h04
`define OP_ROL_ACC   6'h05
`define OP_ROL_MEM   6'h06
`define OP_ROLC_ACC  6'h07
`define OP_ROLC_MEM  6'h08
`define OP_MOV_AM    6'h09
`define OP_MOV_MA    6'h0A
`define OP_MOV_AX    6'h0B
`define OP_BIT_CLR   6'h0C
`define OP_BIT_SET   6'h0D
`define OP_JUMP      6'h0E
`define OP_SKZ       6'h0F
`define OP_SKZ_ACC   6'h10
`define OP_SKBZ      6'h11
`define OP_SKBS      6'h12
`define OP_INCSK     6'h13
`define OP_DECSK     6'h14
`define OP_INCSK_ACC 6'h15
`define OP_DECSK_ACC 6'h16
`define OP_CALL      6'h17
`define OP_RET       6'h18
`define OP_RET_AX    6'h19
`define OP_IRET      6'h1A
`define OP_TBL_CUR   6'h1B
`define OP_TBL_LAST  6'h1C
`define OP_BYTE_CLR  6'h1D
`define OP_BYTE_SET  6'h1E
`define OP_WDT_CLR   6'h1F
`define OP_WDT_PRE1  6'h20
`define OP_WDT_PRE2  6'h21
`define OP_SWAP_MEM  6'h22
`define OP_SWAP_ACC  6'h23
`define OP_HALT      6'h24

`endif

// ### src/instr_core.v
`timescale 1ns/1ps
`default_nettype none
`include "instr_core_defs.vh"

module instr_core #(
  parameter [15:0] WDT_LIMIT = `WDT_PERIOD
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [13:0] adr_i,
  input  wire [31:0] dat_i,
  input  wire [3:0]  sel_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  output reg         sleeping,
  output reg         timeoutFlag
);

  reg  [7:0]  dmem [0:63];
  reg  [15:0] pmem [0:2047];
  reg  [31:0] instrReg;
  reg  [7:0]  accReg;
  reg  [10:0] pcReg;
  reg  [10:0] stack0Reg;
  reg  [10:0] stack1Reg;
  reg  [7:0]  tabHighReg;
  reg         carryReg;
  reg         pwrDownReg;
  reg         ienReg;
  reg         skipReg;
  reg         wdtEnReg;
  reg  [15:0] wdtCount;
  reg  [1:0]  preReg;
  reg         pendingReg;
  reg         extraReg;
  reg  [1:0]  cyclesReg;

  // merge byte lanes of a write
  function [31:0] mergeBytes;
    input [31:0] oldVal;
    input [31:0] newVal;
    input [3:0]  sel;
    integer k;
    begin
      mergeBytes = oldVal;
      for (k = 0; k < 4; k = k + 1) begin
        if (sel[k]) begin
          mergeBytes[k*8 +: 8] = newVal[k*8 +: 8];
        end
      end
    end
  endfunction

  wire        busy     = pendingReg | extraReg;
  wire        busWrite = cyc_i & stb_i & we_i & ack_o;
  wire [5:0]  op       = instrReg[`OP_MSB:`OP_LSB];
  wire [2:0]  bitSel   = instrReg[`BIT_MSB:`BIT_LSB];
  wire [5:0]  ma       = instrReg[`MA_MSB:`MA_LSB];
  wire [7:0]  imm      = instrReg[`IMM_MSB:`IMM_LSB];
  wire [10:0] target   = instrReg[`TGT_MSB:`TGT_LSB];
  // program counter low reads through its data location
  wire [7:0]  mval     = (ma == `PCLOW_LOC) ? pcReg[7:0] : dmem[ma];
  wire [10:0] tblAddr  = (op == `OP_TBL_LAST) ? {`LAST_PAGE, dmem[`TBLP_LOC]}
                                              : {pcReg[10:8], dmem[`TBLP_LOC]};
  wire [15:0] tblWord  = pmem[tblAddr];
  wire [7:0]  incVal   = mval + 8'h01;
  wire [7:0]  decVal   = mval - 8'h01;
  wire [31:0] wdata    = mergeBytes(32'h0000_0000, dat_i, sel_i);
  wire [31:0] pmemMerge = mergeBytes({16'h0000, pmem[adr_i[12:2]]}, dat_i, sel_i);
  wire [31:0] pcMerge   = mergeBytes({21'h000000, pcReg}, dat_i, sel_i);
  wire        dmemHit  = (adr_i[13:8] == `ADR_DMEM_BASE >> 8);
  wire        pmemHit  = adr_i[13];

  reg  [7:0]  res;
  reg         wrMem;
  reg         wrAcc;
  reg         carryNext;
  reg         skip;
  reg         twoCycle;
  reg         pcLoad;
  reg         push;
  reg         pop;

  always @* begin
    res       = mval;
    wrMem     = 1'b0;
    wrAcc     = 1'b0;
    carryNext = carryReg;
    skip      = 1'b0;
    twoCycle  = 1'b0;
    pcLoad    = 1'b0;
    push      = 1'b0;
    pop       = 1'b0;
    case (op)
      `OP_ROR_ACC, `OP_ROR_MEM: begin
        res   = {mval[0], mval[7:1]};
        wrAcc = (op == `OP_ROR_ACC);
        wrMem = (op == `OP_ROR_MEM);
      end
      `OP_RORC_ACC, `OP_RORC_MEM: begin
        res       = {carryReg, mval[7:1]};
        carryNext = mval[0];
        wrAcc     = (op == `OP_RORC_ACC);
        wrMem     = (op == `OP_RORC_MEM);
      end
      `OP_ROL_ACC, `OP_ROL_MEM: begin
        res   = {mval[6:0], mval[7]};
        wrAcc = (op == `OP_ROL_ACC);
        wrMem = (op == `OP_ROL_MEM);
      end
      `OP_ROLC_ACC, `OP_ROLC_MEM: begin
        res       = {mval[6:0], carryReg};
        carryNext = mval[7];
        wrAcc     = (op == `OP_ROLC_ACC);
        wrMem     = (op == `OP_ROLC_MEM);
      end
      `OP_MOV_AM: begin
        wrAcc = 1'b1;
      end
      `OP_MOV_MA: begin
        res   = accReg;
        wrMem = 1'b1;
      end
      `OP_MOV_AX: begin
        res   = imm;
        wrAcc = 1'b1;
      end
      `OP_BIT_CLR, `OP_BIT_SET: begin
        res         = mval;
        res[bitSel] = (op == `OP_BIT_SET);
        wrMem       = 1'b1;
      end
      `OP_JUMP: begin
        pcLoad   = 1'b1;
        twoCycle = 1'b1;
      end
      `OP_SKZ: begin
        skip = (mval == 8'h00);
      end
      `OP_SKZ_ACC: begin
        wrAcc = 1'b1;
        skip  = (mval == 8'h00);
      end
      `OP_SKBZ: begin
        skip = ~mval[bitSel];
      end
      `OP_SKBS: begin
        skip = mval[bitSel];
      end
      `OP_INCSK, `OP_INCSK_ACC: begin
        res   = incVal;
        skip  = (incVal == 8'h00);
        wrAcc = (op == `OP_INCSK_ACC);
        wrMem = (op == `OP_INCSK);
      end
      `OP_DECSK, `OP_DECSK_ACC: begin
        res   = decVal;
        skip  = (decVal == 8'h00);
        wrAcc = (op == `OP_DECSK_ACC);
        wrMem = (op == `OP_DECSK);
      end
      `OP_CALL: begin
        push     = 1'b1;
        pcLoad   = 1'b1;
        twoCycle = 1'b1;
      end
      `OP_RET, `OP_IRET: begin
        pop      = 1'b1;
        twoCycle = 1'b1;
      end
      `OP_RET_AX: begin
        pop      = 1'b1;
        res      = imm;
        wrAcc    = 1'b1;
        twoCycle = 1'b1;
      end
      `OP_TBL_CUR, `OP_TBL_LAST: begin
        res      = tblWord[7:0];
        wrMem    = 1'b1;
        twoCycle = 1'b1;
      end
      `OP_BYTE_CLR: begin
        res   = 8'h00;
        wrMem = 1'b1;
      end
      `OP_BYTE_SET: begin
        res   = 8'hFF;
        wrMem = 1'b1;
      end
      `OP_SWAP_MEM, `OP_SWAP_ACC: begin
        res   = {mval[3:0], mval[7:4]};
        wrAcc = (op == `OP_SWAP_ACC);
        wrMem = (op == `OP_SWAP_MEM);
      end
      default: begin
        res = mval;
      end
    endcase
    // program counter low write costs a cycle
    if (skip || (wrMem && ma == `PCLOW_LOC)) begin
      twoCycle = 1'b1;
    end
  end

  wire preClearHit = (op == `OP_WDT_PRE1 && preReg == 2'b10) ||
                     (op == `OP_WDT_PRE2 && preReg == 2'b01);
  wire wdtClear    = pendingReg && (op == `OP_WDT_CLR || op == `OP_HALT || preClearHit);
  wire wdtExpire   = wdtEnReg && (wdtCount == WDT_LIMIT);

  // watchdog counter and its flags
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdtCount    <= 16'h0000;
      timeoutFlag <= 1'b0;
      pwrDownReg  <= 1'b0;
      preReg      <= 2'b00;
    end else begin
      if (wdtClear || wdtExpire || !wdtEnReg) begin
        wdtCount <= 16'h0000;
      end else begin
        wdtCount <= wdtCount + 16'h0001;
      end
      if (pendingReg) begin
        // pair must be back to back
        if (op == `OP_WDT_CLR || preClearHit) begin
          timeoutFlag <= 1'b0;
          pwrDownReg  <= 1'b0;
        end
        if (op == `OP_HALT) begin
          timeoutFlag <= 1'b0;
          pwrDownReg  <= 1'b1;
        end
        if (op == `OP_WDT_PRE1) begin
          preReg <= preClearHit ? 2'b00 : 2'b01;
        end else if (op == `OP_WDT_PRE2) begin
          preReg <= preClearHit ? 2'b00 : 2'b10;
        end else begin
          preReg <= 2'b00;
        end
      end
      // expiry wins over a clear in the same cycle
      if (wdtExpire) begin
        timeoutFlag <= 1'b1;
      end
    end
  end

  // bus slave and execution
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_o      <= 1'b0;
      dat_o      <= 32'h0000_0000;
      instrReg   <= 32'h0000_0000;
      accReg     <= 8'h00;
      pcReg      <= 11'h000;
      stack0Reg  <= 11'h000;
      stack1Reg  <= 11'h000;
      tabHighReg <= 8'h00;
      carryReg   <= 1'b0;
      ienReg     <= 1'b0;
      skipReg    <= 1'b0;
      wdtEnReg   <= 1'b0;
      sleeping   <= 1'b0;
      pendingReg <= 1'b0;
      extraReg   <= 1'b0;
      cyclesReg  <= 2'b00;
    end else begin
      ack_o    <= cyc_i & stb_i & ~ack_o;
      extraReg <= 1'b0;
      if (cyc_i && stb_i && !ack_o) begin
        dat_o <= 32'h0000_0000;
        if (dmemHit) begin
          dat_o <= {24'h000000, (adr_i[7:2] == `PCLOW_LOC) ? pcReg[7:0] : dmem[adr_i[7:2]]};
        end else if (pmemHit) begin
          dat_o <= {16'h0000, pmem[adr_i[12:2]]};
        end else begin
          case (adr_i)
            `ADR_INSTR:  dat_o <= instrReg;
            `ADR_STATUS: dat_o <= {25'h0000000, ienReg, skipReg, sleeping, carryReg,
                                   timeoutFlag, pwrDownReg, busy};
            `ADR_ACC:    dat_o <= {24'h000000, accReg};
            `ADR_PC:     dat_o <= {21'h000000, pcReg};
            `ADR_TABHI:  dat_o <= {24'h000000, tabHighReg};
            `ADR_CTRL:   dat_o <= {30'h00000000, wdtEnReg, 1'b0};
            `ADR_CYCLES: dat_o <= {30'h00000000, cyclesReg};
            default:     dat_o <= 32'h0000_0000;
          endcase
        end
      end
      if (busWrite && !busy) begin
        if (pmemHit) begin
          pmem[adr_i[12:2]] <= pmemMerge[15:0];
        end else if (dmemHit && sel_i[0]) begin
          if (adr_i[7:2] == `PCLOW_LOC) begin
            pcReg[7:0] <= wdata[7:0];
          end else begin
            dmem[adr_i[7:2]] <= wdata[7:0];
          end
        end else begin
          case (adr_i)
            `ADR_INSTR: begin
              if (!sleeping) begin
                instrReg   <= mergeBytes(instrReg, dat_i, sel_i);
                pendingReg <= 1'b1;
              end
            end
            `ADR_STATUS: if (sel_i[0]) carryReg <= wdata[`ST_CARRY];
            `ADR_ACC:    if (sel_i[0]) accReg <= wdata[7:0];
            `ADR_PC:     pcReg <= pcMerge[10:0];
            `ADR_CTRL: begin
              if (sel_i[0]) begin
                wdtEnReg <= wdata[`CT_WDTEN];
                if (wdata[`CT_WAKE]) sleeping <= 1'b0;
              end
            end
            default: accReg <= accReg;
          endcase
        end
      end
      if (wdtExpire && sleeping) begin
        sleeping <= 1'b0;
      end
      if (pendingReg) begin
        pendingReg <= 1'b0;
        extraReg   <= twoCycle;
        cyclesReg  <= twoCycle ? 2'd2 : 2'd1;
        skipReg    <= skip;
        carryReg   <= carryNext;
        pcReg      <= pcReg + 11'h001;
        if (skip) begin
          pcReg <= pcReg + 11'h002;
        end
        if (pcLoad) begin
          pcReg <= target;
        end
        if (push) begin
          stack0Reg <= pcReg + 11'h001;
          stack1Reg <= stack0Reg;
        end
        if (pop) begin
          pcReg     <= stack0Reg;
          stack0Reg <= stack1Reg;
        end
        if (op == `OP_IRET) begin
          ienReg <= 1'b1;
        end
        if (op == `OP_TBL_CUR || op == `OP_TBL_LAST) begin
          tabHighReg <= tblWord[15:8];
        end
        if (op == `OP_HALT) begin
          sleeping <= 1'b1;
        end
        if (wrAcc) begin
          accReg <= res;
        end
        if (wrMem) begin
          if (ma == `PCLOW_LOC) begin
            pcReg <= {pcReg[10:8], res};
          end else begin
            dmem[ma] <= res;
          end
        end
      end
    end
  end

endmodule

`default_nettype wire

// ### test/core_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "instr_core_defs.vh"
module core_properties #(
  parameter [15:0] WDT_LIMIT = `WDT_PERIOD
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [13:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        sleeping,
  input wire logic        timeoutFlag
);
  logic [5:0] lastOp;
  logic       wakeSeen;
  wire        inAck = ack_o && we_i && adr_i == `ADR_INSTR && !sleeping;
  wire        wake  = ack_o && we_i && adr_i == `ADR_CTRL && dat_i[`CT_WAKE];
  wire  [5:0] opIn  = dat_i[`OP_MSB:`OP_LSB];

  // last accepted instruction, for the preclear pairing
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lastOp   <= `OP_NOP;
      wakeSeen <= 1'b0;
    end else begin
      wakeSeen <= wake;
      if (inAck) begin
        lastOp <= opIn;
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence haltAck;
    inAck && opIn == `OP_HALT;
  endsequence
  sequence pairDone;
    inAck && (opIn == `OP_WDT_PRE2 && lastOp == `OP_WDT_PRE1 ||
      opIn == `OP_WDT_PRE1 && lastOp == `OP_WDT_PRE2);
  endsequence
  sequence halted;
    sleeping && !timeoutFlag;
  endsequence

  AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acked in the next cycle");
  AST_ACK_ONE: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  AST_HALT_SLEEP: assert property (haltAck |-> ##[1:3] halted)
    else $error("halt did not sleep with timeout clear");
  AST_SLEEP_HOLD: assert property (sleeping && !wake && !wakeSeen |=>
    sleeping || timeoutFlag)
    else $error("sleep left without wake");
  AST_WDT_CLR: assert property (
    inAck && opIn == `OP_WDT_CLR |-> ##[1:3] !timeoutFlag)
    else $error("watchdog clear kept timeout");
  AST_PRE_PAIR: assert property (pairDone |-> ##[1:3] !timeoutFlag)
    else $error("preclear pair kept timeout");
  AST_PRE_LONE: assert property (inAck && opIn == `OP_WDT_PRE1 &&
    lastOp != `OP_WDT_PRE2 && timeoutFlag |=> timeoutFlag [*4])
    else $error("lone preclear changed timeout");
  AST_UNMAPPED: assert property (ack_o && !we_i && adr_i == 14'h0040 |->
    dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule
`default_nettype wire

// ### test/bus_master.sv
`timescale 1ns/1ps
`default_nettype none
module bus_master (
  input  wire logic        clk,
  output var  logic        cyc,
  output var  logic        stb,
  output var  logic        we,
  output var  logic [13:0] adr,
  output var  logic [31:0] datW,
  output var  logic [3:0]  sel,
  input  wire logic        ack,
  input  wire logic [31:0] datR
);
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 14'h0000;
    datW = 32'h0000_0000;
    sel = 4'h0;
  end

  task automatic req(input logic w, input logic [13:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datW <= d;
    sel <= 4'hF;
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    datW <= ~d;
  endtask

  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    req(1'b1, a, d);
  endtask

  task automatic rd(input logic [13:0] a, output logic [31:0] d);
    req(1'b0, a, 32'h0000_0000);
    d = datR;
  endtask
endmodule
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "instr_core_defs.vh"
module tb_top;
  localparam logic [15:0] WLIM = 16'h0014;
  logic        clk = 1'b0;
  logic        rstN = 1'b0;
  logic        cyc, stb, we, ack, sleeping, timeoutFlag;
  logic [13:0] adr;
  logic [31:0] datW, datR, v;
  logic [3:0]  sel;
  logic [5:0]  rets [3] = '{`OP_RET, `OP_RET_AX, `OP_IRET};
  int          mismatches = 0;
  int          cmp_count = 0;

  always #5 clk = ~clk;

  bus_master i_bm (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
    .datW(datW), .sel(sel), .ack(ack), .datR(datR));
  instr_core #(.WDT_LIMIT(WLIM)) i_dut (.clk(clk), .rst_n(rstN), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(datW), .sel_i(sel), .dat_o(datR),
    .ack_o(ack), .sleeping(sleeping), .timeoutFlag(timeoutFlag));

  function automatic logic [13:0] dA(input logic [5:0] n);
    return `ADR_DMEM_BASE + {6'h00, n, 2'h0};
  endfunction
  function automatic logic [31:0] ins(input logic [5:0] op, input logic [2:0] b,
      input logic [5:0] ma, input logic [10:0] x);
    return {5'h00, x, ma, 1'b0, b, op};
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rdChk(input string nm, input logic [13:0] a, input logic [31:0] exp);
    logic [31:0] d;
    i_bm.rd(a, d);
    chk(nm, exp, d);
  endtask
  task automatic exec(input logic [31:0] i);
    logic [31:0] s;
    s = 32'h0000_0001;
    i_bm.wr(`ADR_INSTR, i);
    for (int n = 0; n < 20 && s[0] !== 1'b0; n++) i_bm.rd(`ADR_STATUS, s);
    if (s[0] !== 1'b0) mismatches++;
  endtask
  // one instruction from a known start: acc 5A, carry 1, pc 010
  task automatic t(input logic [5:0] op, input logic [2:0] b, input logic [5:0] ma,
      input logic [10:0] x, input logic [7:0] m0, input logic [7:0] a,
      input logic [7:0] m, input logic c, input logic [1:0] cy, input logic [10:0] pc);
    logic [31:0] s;
    i_bm.wr(dA(ma), {24'h0, m0});
    i_bm.wr(`ADR_ACC, 32'h0000_005A);
    i_bm.wr(`ADR_STATUS, 32'h0000_0008);
    i_bm.wr(`ADR_PC, 32'h0000_0010);
    exec(ins(op, b, ma, x));
    rdChk("acc", `ADR_ACC, {24'h0, a});
    if (ma != `PCLOW_LOC) begin
      rdChk("mem", dA(ma), {24'h0, m});
    end
    i_bm.rd(`ADR_STATUS, s);
    chk("flags", {29'h0, c, 2'h0}, {29'h0, s[3:1]});
    rdChk("cycles", `ADR_CYCLES, {30'h0, cy});
    rdChk("pc", `ADR_PC, {21'h0, pc});
  endtask
  task automatic toSet;
    i_bm.wr(`ADR_CTRL, 32'h0000_0002);
    for (int n = 0; n < 200 && timeoutFlag !== 1'b1; n++) @(posedge clk);
    i_bm.wr(`ADR_CTRL, 32'h0000_0000);
    chk("timeout", 32'h1, {31'h0, timeoutFlag});
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results;
  end

  initial begin
    repeat (12) @(posedge clk);
    rstN <= 1'b1;
    @(posedge clk);
    i_bm.wr(dA(`TBLP_LOC), 32'h0000_0004);
    i_bm.wr(`ADR_PMEM_BASE + 14'h0010, 32'h0000_12C3);
    i_bm.wr(`ADR_PMEM_BASE + 14'h1C10, 32'h0000_34D5);
    t(`OP_ROR_ACC, 0, 5, 0, 8'h81, 8'hC0, 8'h81, 1, 1, 11'h011);
    t(`OP_ROR_MEM, 0, 5, 0, 8'h81, 8'h5A, 8'hC0, 1, 1, 11'h011);
    t(`OP_RORC_ACC, 0, 5, 0, 8'h02, 8'h81, 8'h02, 0, 1, 11'h011);
    t(`OP_RORC_MEM, 0, 5, 0, 8'h02, 8'h5A, 8'h81, 0, 1, 11'h011);
    t(`OP_ROL_ACC, 0, 5, 0, 8'h81, 8'h03, 8'h81, 1, 1, 11'h011);
    t(`OP_ROL_MEM, 0, 5, 0, 8'h81, 8'h5A, 8'h03, 1, 1, 11'h011);
    t(`OP_ROLC_ACC, 0, 5, 0, 8'h02, 8'h05, 8'h02, 0, 1, 11'h011);
    t(`OP_ROLC_MEM, 0, 5, 0, 8'h02, 8'h5A, 8'h05, 0, 1, 11'h011);
    t(`OP_MOV_AM, 0, 5, 0, 8'h81, 8'h81, 8'h81, 1, 1, 11'h011);
    t(`OP_MOV_MA, 0, 5, 0, 8'h81, 8'h5A, 8'h5A, 1, 1, 11'h011);
    t(`OP_MOV_AX, 0, 5, 11'h033, 8'h81, 8'h33, 8'h81, 1, 1, 11'h011);
    t(`OP_BIT_CLR, 7, 5, 0, 8'h81, 8'h5A, 8'h01, 1, 1, 11'h011);
    t(`OP_BIT_SET, 1, 5, 0, 8'h81, 8'h5A, 8'h83, 1, 1, 11'h011);
    t(`OP_JUMP, 0, 5, 11'h123, 8'h81, 8'h5A, 8'h81, 1, 2, 11'h123);
    t(`OP_SKZ, 0, 5, 0, 8'h00, 8'h5A, 8'h00, 1, 2, 11'h012);
    t(`OP_SKZ, 0, 5, 0, 8'h81, 8'h5A, 8'h81, 1, 1, 11'h011);
    t(`OP_SKZ_ACC, 0, 5, 0, 8'h00, 8'h00, 8'h00, 1, 2, 11'h012);
    t(`OP_SKBZ, 0, 5, 0, 8'h81, 8'h5A, 8'h81, 1, 1, 11'h011);
    t(`OP_SKBS, 0, 5, 0, 8'h81, 8'h5A, 8'h81, 1, 2, 11'h012);
    t(`OP_INCSK, 0, 5, 0, 8'hFF, 8'h5A, 8'h00, 1, 2, 11'h012);
    t(`OP_DECSK, 0, 5, 0, 8'h01, 8'h5A, 8'h00, 1, 2, 11'h012);
    t(`OP_INCSK_ACC, 0, 5, 0, 8'hFF, 8'h00, 8'hFF, 1, 2, 11'h012);
    t(`OP_DECSK_ACC, 0, 5, 0, 8'h02, 8'h01, 8'h02, 1, 1, 11'h011);
    t(`OP_TBL_CUR, 0, 5, 0, 8'h81, 8'h5A, 8'hC3, 1, 2, 11'h011);
    rdChk("tabhigh", `ADR_TABHI, 32'h0000_0012);
    t(`OP_TBL_LAST, 0, 5, 0, 8'h81, 8'h5A, 8'hD5, 1, 2, 11'h011);
    rdChk("tabhigh", `ADR_TABHI, 32'h0000_0034);
    t(`OP_NOP, 0, 5, 0, 8'h81, 8'h5A, 8'h81, 1, 1, 11'h011);
    t(`OP_BYTE_CLR, 0, 5, 0, 8'h81, 8'h5A, 8'h00, 1, 1, 11'h011);
    t(`OP_BYTE_SET, 0, 5, 0, 8'h81, 8'h5A, 8'hFF, 1, 1, 11'h011);
    t(`OP_SWAP_MEM, 0, 5, 0, 8'h81, 8'h5A, 8'h18, 1, 1, 11'h011);
    t(`OP_SWAP_ACC, 0, 5, 0, 8'h81, 8'h18, 8'h81, 1, 1, 11'h011);
    t(`OP_MOV_MA, 0, `PCLOW_LOC, 0, 8'h00, 8'h5A, 8'h00, 1, 2, 11'h05A);
    for (int j = 0; j < 3; j++) begin
      i_bm.wr(`ADR_PC, 32'h0000_0010);
      exec(ins(`OP_CALL, 3'h0, 6'h00, 11'h200));
      rdChk("call", `ADR_PC, 32'h0000_0200);
      rdChk("callcyc", `ADR_CYCLES, 32'h0000_0002);
      exec(ins(rets[j], 3'h0, 6'h00, 11'h077));
      rdChk("ret", `ADR_PC, 32'h0000_0011);
      rdChk("retcyc", `ADR_CYCLES, 32'h0000_0002);
    end
    rdChk("retacc", `ADR_ACC, 32'h0000_0077);
    toSet;
    i_bm.wr(`ADR_INSTR, ins(`OP_HALT, 3'h0, 6'h00, 11'h000));
    repeat (4) @(posedge clk);
    chk("sleep", 32'h1, {31'h0, sleeping});
    i_bm.rd(`ADR_STATUS, v);
    chk("haltflags", 32'h1, {30'h0, v[2:1]});
    i_bm.wr(`ADR_CTRL, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("woken", 32'h0, {31'h0, sleeping});
    toSet;
    exec(ins(`OP_WDT_CLR, 3'h0, 6'h00, 11'h000));
    i_bm.rd(`ADR_STATUS, v);
    chk("wdtclr", 32'h0, {30'h0, v[2:1]});
    toSet;
    exec(ins(`OP_WDT_PRE1, 3'h0, 6'h00, 11'h000));
    exec(ins(`OP_NOP, 3'h0, 6'h00, 11'h000));
    chk("lone1", 32'h1, {31'h0, timeoutFlag});
    exec(ins(`OP_WDT_PRE2, 3'h0, 6'h00, 11'h000));
    chk("lone2", 32'h1, {31'h0, timeoutFlag});
    exec(ins(`OP_WDT_PRE1, 3'h0, 6'h00, 11'h000));
    chk("pair", 32'h0, {31'h0, timeoutFlag});
    i_bm.wr(`ADR_CTRL, 32'h0000_0002);
    i_bm.wr(`ADR_INSTR, ins(`OP_HALT, 3'h0, 6'h00, 11'h000));
    repeat (4) @(posedge clk);
    for (int n = 0; n < 200 && sleeping !== 1'b0; n++) @(posedge clk);
    chk("tmowake", 32'h1, {31'h0, timeoutFlag});
    i_bm.wr(`ADR_CTRL, 32'h0000_0000);
    i_bm.wr(14'h0040, 32'hFFFF_FFFF);
    rdChk("unmapped", 14'h0040, 32'h0000_0000);
    results;
  end
endmodule

bind instr_core core_properties #(.WDT_LIMIT(WDT_LIMIT)) i_props (.clk(clk),
  .rst_n(rst_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
  .sleeping(sleeping), .timeoutFlag(timeoutFlag));
`default_nettype wire
